// [rtl/smpcg_pkg.sv]
// What this block does
// - A port whose bit is one is clocked in Sleep; at zero it is gated off.
// - A bus access to a port whose clock is gated off ends in a bus fault.
// - Reset clears every port enable bit, so all ports start unclocked.
// - The sleep register steers gating only in Sleep, other sets elsewhere.
// - Sleep settings apply only with auto gating selected, else run ones.
// - Enable bits for ports A to E sit at bits 0 to 4, each read and write.
// - Bits 31 to 5 read zero and ignore writes; software keeps them intact.
package smpcg_pkg;

	localparam int NUM_PORTS = 5;
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;

	localparam logic [ADDR_W-1:0] SLEEP_GATE_OFFSET = 12'h118;
	localparam logic [ADDR_W-1:0] FAULT_STATUS_OFFSET = 12'h200;
	localparam logic [ADDR_W-1:0] FAULT_MASK_OFFSET = 12'h204;

	localparam int PORT_A_POS = 0;
	localparam int PORT_E_POS = 4;
	localparam logic [NUM_PORTS-1:0] SLEEP_GATE_RESET = 5'h00;
	localparam logic [NUM_PORTS-1:0] FAULT_STATUS_RESET = 5'h00;
	localparam logic [NUM_PORTS-1:0] FAULT_MASK_RESET = 5'h00;
	localparam logic [DATA_W-1:0] READ_ZERO = 32'h00000000;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic wr;
		logic rd;
	} smpcg_bus_req_type;

	typedef struct packed {
		logic auto_clock_gating_select;
		logic sleepMode;
		logic deepSleepMode;
	} smpcg_power_state_type;

	typedef enum logic [1:0] {
		SRC_RUN,
		SRC_SLEEP,
		SRC_DEEP
	} smpcg_source_type;

endpackage : smpcg_pkg

// [rtl/smpcg_gate_ctrl.sv]
`timescale 1ns/10ps
module smpcg_gate_ctrl
	import smpcg_pkg::*;
(
	// Clock and reset
	input wire logic mclk,
	input wire logic sys_rst,
	// Settings and source
	input wire logic runEn,
	input wire logic sleepEn,
	input wire logic deepEn,
	input smpcg_source_type source,
	// Registered clock enable
	output logic clockEnable
);

	logic clockEnableNext;

	always_comb begin
		case (source)
			SRC_SLEEP: clockEnableNext = sleepEn;
			SRC_DEEP: clockEnableNext = deepEn;
			SRC_RUN: clockEnableNext = runEn;
			default: clockEnableNext = runEn;
		endcase
	end

	// One flop per port, so the gate enable never glitches
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			clockEnable <= 1'b0;
		end else begin
			clockEnable <= clockEnableNext;
		end
	end

endmodule : smpcg_gate_ctrl

// [rtl/smpcg_top.sv]
`timescale 1ns/10ps
module smpcg_top
	import smpcg_pkg::*;
(
	// Clock and reset
	input wire logic mclk,
	input wire logic sys_rst,
	// Register port
	input smpcg_bus_req_type busReq,
	output logic [DATA_W-1:0] busRdata,
	// Companion settings and power state
	input wire logic [NUM_PORTS-1:0] run_port_clock_gate,
	input wire logic [NUM_PORTS-1:0] deep_sleep_port_clock_gate,
	input smpcg_power_state_type powerState,
	// Port access check
	input wire logic [NUM_PORTS-1:0] portAccess,
	output logic [NUM_PORTS-1:0] portBusFault,
	// Gated port clock enables
	output logic [NUM_PORTS-1:0] portClockEnable,
	// Interrupt
	output logic irq
);

	logic [NUM_PORTS-1:0] sleepGate_reg;
	logic [NUM_PORTS-1:0] faultStatus_reg;
	logic [NUM_PORTS-1:0] faultMask_reg;
	logic [NUM_PORTS-1:0] faultMask_next;
	logic [NUM_PORTS-1:0] faultEvent;
	logic [NUM_PORTS-1:0] faultStatus_next;
	logic [DATA_W-1:0] rdata_next;
	logic statusRead;
	smpcg_source_type source;

	function automatic logic hit(input smpcg_bus_req_type req,
		input logic [ADDR_W-1:0] offset);
		hit = req.addr == offset;
	endfunction : hit

	function automatic logic [DATA_W-1:0] widen(
		input logic [NUM_PORTS-1:0] v);
		widen = {{(DATA_W-NUM_PORTS){1'b0}}, v};
	endfunction : widen

	// Which register set drives gating now
	always_comb begin
		if (!powerState.auto_clock_gating_select) begin
			source = SRC_RUN;
		end else if (powerState.deepSleepMode) begin
			source = SRC_DEEP;
		end else if (powerState.sleepMode) begin
			source = SRC_SLEEP;
		end else begin
			source = SRC_RUN;
		end
	end

	// Sleep gating register, bits 4:0 only
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			sleepGate_reg <= SLEEP_GATE_RESET;
		end else if (busReq.wr && hit(busReq, SLEEP_GATE_OFFSET)) begin
			sleepGate_reg <= busReq.wdata[PORT_E_POS:PORT_A_POS];
		end
	end

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			faultMask_reg <= FAULT_MASK_RESET;
		end else begin
			faultMask_reg <= faultMask_next;
		end
	end

	// Mask write seen by irq in the same cycle
	always_comb begin
		faultMask_next = faultMask_reg;
		if (busReq.wr && hit(busReq, FAULT_MASK_OFFSET)) begin
			faultMask_next = busReq.wdata[NUM_PORTS-1:0];
		end
	end

	genvar i;
	generate
		for (i = 0; i < NUM_PORTS; i++) begin : g_port
			smpcg_gate_ctrl u_gate (
				.mclk(mclk),
				.sys_rst(sys_rst),
				.runEn(run_port_clock_gate[i]),
				.sleepEn(sleepGate_reg[i]),
				.deepEn(deep_sleep_port_clock_gate[i]),
				.source(source),
				.clockEnable(portClockEnable[i])
			);
		end
	endgenerate

	// Access to an unclocked port faults
	assign faultEvent = portAccess & ~portClockEnable;

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			portBusFault <= '0;
		end else begin
			portBusFault <= faultEvent;
		end
	end

	// Sticky status, cleared by read; a new event wins
	assign statusRead = busReq.rd && hit(busReq, FAULT_STATUS_OFFSET);
	always_comb begin
		faultStatus_next = statusRead ? '0 : faultStatus_reg;
		faultStatus_next = faultStatus_next | faultEvent;
	end

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			faultStatus_reg <= FAULT_STATUS_RESET;
		end else begin
			faultStatus_reg <= faultStatus_next;
		end
	end

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			irq <= 1'b0;
		end else begin
			irq <= |(faultStatus_next & faultMask_next);
		end
	end

	// Read data in the cycle after the strobe only
	always_comb begin
		rdata_next = READ_ZERO;
		if (busReq.rd) begin
			if (hit(busReq, SLEEP_GATE_OFFSET)) begin
				rdata_next = widen(sleepGate_reg);
			end else if (hit(busReq, FAULT_STATUS_OFFSET)) begin
				rdata_next = widen(faultStatus_reg);
			end else if (hit(busReq, FAULT_MASK_OFFSET)) begin
				rdata_next = widen(faultMask_reg);
			end
		end
	end

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			busRdata <= READ_ZERO;
		end else begin
			busRdata <= rdata_next;
		end
	end

endmodule : smpcg_top

// [test/smpcg_monitor.sv]
`timescale 1ns/10ps
module smpcg_monitor import smpcg_pkg::*; (
	// Top ports
	input wire logic mclk,
	input wire logic sys_rst,
	input smpcg_bus_req_type busReq,
	input logic [31:0] busRdata,
	input smpcg_power_state_type powerState,
	input wire logic [4:0] run_port_clock_gate,
	input wire logic [4:0] portAccess,
	input logic [4:0] portBusFault,
	input logic [4:0] portClockEnable
);
	default clocking @(posedge mclk); endclocking
	default disable iff (sys_rst);
	logic [4:0] hit;
	logic sel, slp;
	assign hit = portAccess & ~portClockEnable;
	assign sel = busReq.addr == SLEEP_GATE_OFFSET;
	assign slp = powerState == 3'h6;
	fault_set_a: assert property (|hit |=> portBusFault == $past(hit))
		else $error("fault");
	fault_cause_a: assert property (|portBusFault |-> $past(|hit))
		else $error("cause");
	run_sel_a: assert property (!powerState.auto_clock_gating_select
		|=> portClockEnable == $past(run_port_clock_gate)) else $error("run");
	sleep_sel_a: assert property (busReq.wr && sel
		##1 slp && !(busReq.wr && sel)
		|=> portClockEnable == $past(busReq.wdata[4:0], 2)) else $error("slp");
	reset_clr_a: assert property ($fell(sys_rst) |-> !portClockEnable)
		else $error("rst");
	rsvd_zero_a: assert property (busRdata[31:5] == '0) else $error("rsv");
	idle_zero_a: assert property (!$past(busReq.rd) |-> !busRdata)
		else $error("idle");
	sleep_readback_a: assert property (busReq.wr && sel ##1 !busReq.wr
		##1 busReq.rd && sel
		|=> busRdata == ($past(busReq.wdata, 3) & 32'h1F)) else $error("rb");
endmodule : smpcg_monitor

// [test/smpcg_port_model.sv]
`timescale 1ns/10ps
module smpcg_port_model import smpcg_pkg::*; (
	// Port unit access strobes
	input wire logic mclk,
	output logic [4:0] portAccess = '0
);
	task access(input logic [4:0] m);
		@(posedge mclk) portAccess <= m;
		@(posedge mclk) portAccess <= '0;
	endtask : access
endmodule : smpcg_port_model

// [test/testbench.sv]
`timescale 1ns/10ps
module testbench import smpcg_pkg::*; ;
	logic mclk = 0, sys_rst = 1, irq;
	smpcg_bus_req_type busReq = '0;
	smpcg_power_state_type pwr = '0;
	logic [31:0] rdata;
	logic [4:0] acc, flt, en;
	int failures = 0, samples_checked = 0;
	always #50 mclk = ~mclk;
	smpcg_port_model u_port(.mclk(mclk), .portAccess(acc));
	smpcg_top u_dut(.mclk(mclk), .sys_rst(sys_rst), .busReq(busReq),
		.busRdata(rdata), .run_port_clock_gate(5'h11), .powerState(pwr),
		.deep_sleep_port_clock_gate(5'h1F), .portAccess(acc),
		.portBusFault(flt), .portClockEnable(en), .irq(irq));
	task conclude;
		if (failures == 0 && samples_checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : conclude
	task chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		failures += (got !== exp);
		if (got !== exp) $display("ERROR %0t got %h exp %h", $time, got, exp);
	endtask : chk
	task bus(input logic [11:0] a, input logic [31:0] d, input logic w);
		@(posedge mclk) busReq <= '{a, d, w, !w};
		@(posedge mclk) busReq <= '0;
		#1 if (!w) chk(rdata, d);
	endtask : bus
	task gate(input logic [4:0] e);
		repeat (2) @(posedge mclk);
		#1 chk(en, e);
	endtask : gate
	initial begin
		#1000000 failures++;
		conclude;
	end
	initial begin
		repeat (16) @(posedge mclk);
		sys_rst <= 1'h0;
		bus(SLEEP_GATE_OFFSET, READ_ZERO, 1'h0);
		bus(SLEEP_GATE_OFFSET, 32'hFFFFFFEA, 1'h1);
		bus(SLEEP_GATE_OFFSET, 32'h0000000A, 1'h0);
		@(posedge mclk) pwr <= 3'h6;
		gate(5'h0A);
		bus(SLEEP_GATE_OFFSET, 32'h00000004, 1'h1);
		gate(5'h04);
		bus(FAULT_MASK_OFFSET, 32'h0000001F, 1'h1);
		u_port.access(5'h15);
		#1 chk({irq, flt}, 6'h31);
		bus(FAULT_STATUS_OFFSET, 32'h00000011, 1'h0);
		u_port.access(5'h04);
		#1 chk({irq, flt}, 6'h00);
		@(posedge mclk) pwr <= 3'h7;
		gate(5'h1F);
		@(posedge mclk) sys_rst <= 1'h1;
		repeat (2) @(posedge mclk);
		sys_rst <= 1'h0;
		#1 chk(en, 5'h00);
		bus(SLEEP_GATE_OFFSET, READ_ZERO, 1'h0);
		@(posedge mclk) pwr <= 3'h2;
		gate(5'h11);
		@(posedge mclk) pwr <= 3'h4;
		gate(5'h11);
		conclude;
	end
endmodule : testbench
bind smpcg_top smpcg_monitor u_mon(.mclk(mclk), .sys_rst(sys_rst),
	.busReq(busReq), .busRdata(busRdata), .powerState(powerState),
	.run_port_clock_gate(run_port_clock_gate), .portAccess(portAccess),
	.portBusFault(portBusFault), .portClockEnable(portClockEnable));
